/* File: rtl/psl_link.sv */
// serializer and deserializer ends of a 28-bit, four-lane parallel link
// assumes pins are asynchronous to clk_sys; the link clocks are sampled, not used as clocks

`timescale 1ns/1ps

module psl_link #(
  parameter int LOCK_CYCLES = psl_pkg::LOCK_CYCLES_DEFAULT,
  parameter int BIT_CYCLES = psl_pkg::BIT_SYS_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic parallel_strobe_clock_in,
  input wire logic [psl_pkg::WORD_BITS-1:0] parallel_word_in,
  input wire logic tx_low_power_request_n,
  output logic [psl_pkg::LANES-1:0] serial_lane_out,
  output logic serial_lane_oe,
  output logic forwarded_clock_out,
  output logic forwarded_clock_oe,
  output logic tx_word_ready,
  input wire logic forwarded_clock_in,
  input wire logic [psl_pkg::LANES-1:0] serial_lane_in,
  input wire logic rx_low_power_request_n,
  output logic [psl_pkg::WORD_BITS-1:0] parallel_word_out,
  output logic parallel_strobe_clock_out
);
  import psl_pkg::*;

  localparam logic [PHASE_W-1:0] BIT_LAST = PHASE_W'(BIT_CYCLES - 1);
  localparam logic [PHASE_W-1:0] SAMPLE_PHASE = PHASE_W'(BIT_CYCLES / 2);
  localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(LOCK_CYCLES - 1);
  localparam logic [IDLE_W-1:0] IDLE_LIMIT = IDLE_W'(2 * SLOTS * BIT_CYCLES);
  // the edge cycle is already phase 0 of slot 0, so the count resumes one phase on
  localparam logic [PHASE_W-1:0] EDGE_NEXT_PHASE = PHASE_W'(1);

  // ****************************************
  // input synchronisers
  // ****************************************
  logic strobe_s1, strobe_s2, strobe_s3;
  logic [WORD_BITS-1:0] word_s1, word_s2;
  logic tx_pd_s1, tx_pd_s2, rx_pd_s1, rx_pd_s2;
  psl_link_s link_s1, link_s2;
  logic fclk_s3;

  // data and strobe pass equal stages, so the word lines up with the edge
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      strobe_s1 <= 1'b0;
      strobe_s2 <= 1'b0;
      strobe_s3 <= 1'b0;
      word_s1 <= WORD_RESET;
      word_s2 <= WORD_RESET;
      tx_pd_s1 <= 1'b0;
      tx_pd_s2 <= 1'b0;
      rx_pd_s1 <= 1'b0;
      rx_pd_s2 <= 1'b0;
      link_s1 <= '0;
      link_s2 <= '0;
      fclk_s3 <= 1'b0;
    end
    else
    begin
      strobe_s1 <= parallel_strobe_clock_in;
      strobe_s2 <= strobe_s1;
      strobe_s3 <= strobe_s2;
      word_s1 <= parallel_word_in;
      word_s2 <= word_s1;
      tx_pd_s1 <= tx_low_power_request_n;
      tx_pd_s2 <= tx_pd_s1;
      rx_pd_s1 <= rx_low_power_request_n;
      rx_pd_s2 <= rx_pd_s1;
      link_s1 <= '{forwarded_clock: forwarded_clock_in, serial_lane: serial_lane_in};
      link_s2 <= link_s1;
      fclk_s3 <= link_s2.forwarded_clock;
    end
  end

  // ****************************************
  // transmit: capture and buffering
  // ****************************************
  psl_tx_state_e tx_state;
  logic strobe_rise;
  logic cap_valid;
  logic [WORD_BITS-1:0] cap_word;
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [WORD_BITS-1:0] fifo_out_data;

  assign strobe_rise = strobe_s2 && !strobe_s3;

  // words are only taken while the link is running, so no stale frames queue up
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      cap_valid <= 1'b0;
      cap_word <= WORD_RESET;
    end
    else
    begin
      cap_valid <= strobe_rise && (tx_state == PSL_TX_RUN);
      if (strobe_rise)
        cap_word <= word_s2;
    end
  end

  psl_fifo #(
    .WIDTH(WORD_BITS),
    .DEPTH(FIFO_DEPTH)
  ) psl_fifo_i (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_valid(cap_valid),
    .in_ready(fifo_in_ready),
    .in_data(cap_word),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // full buffer shows to the source; a word offered while low is dropped
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      tx_word_ready <= 1'b0;
    else
      tx_word_ready <= fifo_in_ready;
  end

  // ****************************************
  // transmit: power-down and lock
  // ****************************************
  logic [LOCK_W-1:0] lock_cnt;

  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      tx_state <= PSL_TX_OFF;
      lock_cnt <= '0;
    end
    else if (!tx_pd_s2)
    begin
      tx_state <= PSL_TX_OFF;
      lock_cnt <= '0;
    end
    else
    begin
      case (tx_state)
        PSL_TX_OFF:
          tx_state <= PSL_TX_LOCK;
        PSL_TX_LOCK:
        begin
          lock_cnt <= LOCK_W'(lock_cnt + 1'b1);
          if (lock_cnt == LOCK_LAST)
            tx_state <= PSL_TX_RUN;
        end
        PSL_TX_RUN:
          tx_state <= PSL_TX_RUN;
        default:
          tx_state <= PSL_TX_OFF;
      endcase
    end
  end

  // drivers float while power-down is held low
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      serial_lane_oe <= 1'b0;
      forwarded_clock_oe <= 1'b0;
    end
    else
    begin
      serial_lane_oe <= tx_pd_s2;
      forwarded_clock_oe <= tx_pd_s2;
    end
  end

  // ****************************************
  // transmit: serializer
  // ****************************************
  logic [PHASE_W-1:0] tx_div;
  logic [SLOT_W-1:0] tx_slot;
  logic tx_active;
  logic [WORD_BITS-1:0] tx_frame;
  logic tx_bit_start;
  logic tx_frame_end;

  assign tx_bit_start = (tx_state == PSL_TX_RUN) && (tx_div == '0);
  assign tx_frame_end = !tx_active || (tx_slot == LAST_SLOT);
  assign fifo_out_ready = tx_bit_start && tx_frame_end;

  // one frame is seven bit slots; an empty buffer stops the clock low
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      tx_div <= '0;
      tx_slot <= FIRST_SLOT;
      tx_active <= 1'b0;
      tx_frame <= WORD_RESET;
      serial_lane_out <= LANES_IDLE;
      forwarded_clock_out <= 1'b0;
    end
    else if (tx_state != PSL_TX_RUN)
    begin
      tx_div <= '0;
      tx_slot <= FIRST_SLOT;
      tx_active <= 1'b0;
      serial_lane_out <= LANES_IDLE;
      forwarded_clock_out <= 1'b0;
    end
    else if (tx_bit_start)
    begin
      tx_div <= BIT_LAST;
      if (!tx_frame_end)
      begin
        tx_slot <= SLOT_W'(tx_slot + 1'b1);
        serial_lane_out <= psl_lane_bits(tx_frame, SLOT_W'(tx_slot + 1'b1));
        forwarded_clock_out <= (int'(tx_slot) + 1 < FCLK_HIGH_SLOTS);
      end
      else if (fifo_out_valid)
      begin
        tx_active <= 1'b1;
        tx_slot <= FIRST_SLOT;
        tx_frame <= fifo_out_data;
        serial_lane_out <= psl_lane_bits(fifo_out_data, FIRST_SLOT);
        forwarded_clock_out <= 1'b1;
      end
      else
      begin
        tx_active <= 1'b0;
        serial_lane_out <= LANES_IDLE;
        forwarded_clock_out <= 1'b0;
      end
    end
    else
      tx_div <= PHASE_W'(tx_div - 1'b1);
  end

  // ****************************************
  // receive: deserializer
  // ****************************************
  logic fclk_rise;
  logic rx_busy;
  logic [PHASE_W-1:0] rx_phase;
  logic [SLOT_W-1:0] rx_slot;
  logic [WORD_BITS-1:0] rx_word;
  logic rx_done;

  assign fclk_rise = link_s2.forwarded_clock && !fclk_s3;

  // sample mid-bit; a frame that never completes leaves the outputs alone
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      rx_busy <= 1'b0;
      rx_phase <= '0;
      rx_slot <= FIRST_SLOT;
      rx_word <= WORD_RESET;
      rx_done <= 1'b0;
    end
    else
    begin
      rx_done <= 1'b0;
      if (fclk_rise)
      begin
        rx_busy <= 1'b1;
        rx_phase <= EDGE_NEXT_PHASE;
        rx_slot <= FIRST_SLOT;
      end
      else if (rx_busy)
      begin
        if (rx_phase == SAMPLE_PHASE)
        begin
          rx_word <= psl_place_bits(rx_word, link_s2.serial_lane, rx_slot);
          if (rx_slot == LAST_SLOT)
          begin
            rx_busy <= 1'b0;
            rx_done <= 1'b1;
          end
        end
        if (rx_phase == BIT_LAST)
        begin
          rx_phase <= '0;
          rx_slot <= SLOT_W'(rx_slot + 1'b1);
        end
        else
          rx_phase <= PHASE_W'(rx_phase + 1'b1);
      end
    end
  end

  // ****************************************
  // receive: outputs and strobe
  // ****************************************
  logic rx_update;

  // the word output changes only on a completed frame outside power-down
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      parallel_word_out <= WORD_RESET;
      rx_update <= 1'b0;
    end
    else
    begin
      rx_update <= rx_done && rx_pd_s2;
      if (rx_done && rx_pd_s2)
        parallel_word_out <= rx_word;
    end
  end

  // rises one cycle after the word settles, falls at the next frame start
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      parallel_strobe_clock_out <= 1'b0;
    else if (rx_update)
      parallel_strobe_clock_out <= 1'b1;
    else if (fclk_rise || !rx_pd_s2)
      parallel_strobe_clock_out <= 1'b0;
  end

  // ****************************************
  // checks
  // ****************************************
  logic [IDLE_W-1:0] rx_idle_cnt;

  // cycles since the last forwarded clock edge, saturating
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      rx_idle_cnt <= '0;
    else if (fclk_rise)
      rx_idle_cnt <= '0;
    else if (rx_idle_cnt != IDLE_LIMIT)
      rx_idle_cnt <= IDLE_W'(rx_idle_cnt + 1'b1);
  end

  property p_capture;
    @(posedge clk_sys) disable iff (reset)
    strobe_rise |=> (cap_word == $past(word_s2)) && (cap_valid == ($past(tx_state) == PSL_TX_RUN));
  endproperty
  a_capture: assert property (p_capture) else $error("word not captured on strobe edge");

  property p_fclk_shape;
    @(posedge clk_sys) disable iff (reset)
    $rose(forwarded_clock_out) && (BIT_CYCLES == 2) |-> forwarded_clock_out [*8] ##1 !forwarded_clock_out;
  endproperty
  a_fclk_shape: assert property (p_fclk_shape) else $error("forwarded clock high time wrong");

  property p_tristate;
    @(posedge clk_sys) disable iff (reset)
    !tx_pd_s2 |=> !serial_lane_oe && !forwarded_clock_oe;
  endproperty
  a_tristate: assert property (p_tristate) else $error("drivers enabled in power-down");

  property p_lock_quiet;
    @(posedge clk_sys) disable iff (reset)
    (tx_state != PSL_TX_RUN) |=> !forwarded_clock_out && (serial_lane_out == LANES_IDLE);
  endproperty
  a_lock_quiet: assert property (p_lock_quiet) else $error("link toggles before lock");

  property p_lock_time;
    @(posedge clk_sys) disable iff (reset)
    $rose(tx_state == PSL_TX_RUN) |-> $past(lock_cnt) == LOCK_LAST;
  endproperty
  a_lock_time: assert property (p_lock_time) else $error("lock time not honoured");

  property p_lane_map;
    @(posedge clk_sys) disable iff (reset)
    tx_active && (tx_state == PSL_TX_RUN) |-> serial_lane_out == psl_lane_bits(tx_frame, tx_slot);
  endproperty
  a_lane_map: assert property (p_lane_map) else $error("lane bits do not follow mapping");

  property p_rx_word;
    @(posedge clk_sys) disable iff (reset)
    rx_done && rx_pd_s2 |=> (parallel_word_out == $past(rx_word)) ##1 $rose(parallel_strobe_clock_out);
  endproperty
  a_rx_word: assert property (p_rx_word) else $error("rebuilt word or strobe late");

  property p_strobe_valid;
    @(posedge clk_sys) disable iff (reset)
    $rose(parallel_strobe_clock_out) |-> $stable(parallel_word_out) && $past(rx_update);
  endproperty
  a_strobe_valid: assert property (p_strobe_valid) else $error("strobe rose without new word");

  property p_pd_freeze;
    @(posedge clk_sys) disable iff (reset)
    !rx_pd_s2 |=> $stable(parallel_word_out);
  endproperty
  a_pd_freeze: assert property (p_pd_freeze) else $error("outputs moved in power-down");

  property p_clock_loss;
    @(posedge clk_sys) disable iff (reset)
    (rx_idle_cnt == IDLE_LIMIT) && rx_pd_s2 |=> $stable(parallel_word_out) && $stable(parallel_strobe_clock_out);
  endproperty
  a_clock_loss: assert property (p_clock_loss) else $error("outputs moved after clock loss");

endmodule

/* File: rtl/psl_pkg.sv */
// shared constants, carriers and bit mapping for the serial link block
// assumes one 100 MHz system clock; link pins are asynchronous to it

package psl_pkg;

  // ****************************************
  // sizes and timing
  // ****************************************
  localparam int WORD_BITS = 28;
  localparam int LANES = 4;
  localparam int SLOTS = 7;
  localparam int FCLK_HIGH_SLOTS = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int SYS_CLK_HZ = 100_000_000;
  localparam int LOCK_TIME_MS = 10;
  localparam int LOCK_CYCLES_DEFAULT = LOCK_TIME_MS * (SYS_CLK_HZ / 1000);
  localparam int LOCK_W = 21;
  localparam int BIT_SYS_CYCLES = 2;
  localparam int SLOT_W = 3;
  localparam int PHASE_W = 4;
  localparam int IDLE_W = 6;
  localparam logic [SLOT_W-1:0] LAST_SLOT = 3'h6;
  localparam logic [SLOT_W-1:0] FIRST_SLOT = 3'h0;
  localparam logic [LANES-1:0] LANES_IDLE = 4'h0;
  localparam logic [WORD_BITS-1:0] WORD_RESET = 28'h000_0000;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    PSL_TX_OFF = 2'b00,
    PSL_TX_LOCK = 2'b01,
    PSL_TX_RUN = 2'b10
  } psl_tx_state_e;

  // one sample of the five link pairs, true side only
  typedef struct packed {
    logic forwarded_clock;
    logic [LANES-1:0] serial_lane;
  } psl_link_s;

  // ****************************************
  // lane mapping, identical at both ends
  // ****************************************
  function automatic int psl_bit_index(input int lane, input int slot);
    psl_bit_index = lane * SLOTS + slot;
  endfunction

  function automatic logic [LANES-1:0] psl_lane_bits(input logic [WORD_BITS-1:0] word,
                                                     input logic [SLOT_W-1:0] slot);
    logic [LANES-1:0] bits;
    bits = LANES_IDLE;
    for (int l = 0; l < LANES; l++)
    begin
      bits[l] = word[psl_bit_index(l, int'(slot))];
    end
    psl_lane_bits = bits;
  endfunction

  function automatic logic [WORD_BITS-1:0] psl_place_bits(input logic [WORD_BITS-1:0] word,
                                                          input logic [LANES-1:0] bits,
                                                          input logic [SLOT_W-1:0] slot);
    logic [WORD_BITS-1:0] w;
    w = word;
    for (int l = 0; l < LANES; l++)
    begin
      w[psl_bit_index(l, int'(slot))] = bits[l];
    end
    psl_place_bits = w;
  endfunction

endpackage

/* File: rtl/psl_fifo.sv */
// word fifo with a registered read stage
// assumes one clock and an asynchronous active-high reset

`timescale 1ns/1ps

module psl_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);
  localparam logic [PW:0] ZERO_COUNT = '0;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] mem_count;
  logic do_wr;
  logic do_rd;

  // ****************************************
  // handshakes
  // ****************************************
  // full and empty are honest: ready drops only when the array is full
  assign in_ready = (mem_count != FULL_COUNT);
  assign do_wr = in_valid && in_ready;
  assign do_rd = (mem_count != ZERO_COUNT) && (!out_valid || out_ready);

  // storage array, data only, no reset needed
  always_ff @(posedge clk_sys)
  begin
    if (do_wr)
      mem[wr_ptr] <= in_data;
  end

  // pointers and fill level
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      mem_count <= '0;
    end
    else
    begin
      if (do_wr)
        wr_ptr <= PW'(wr_ptr + 1'b1);
      if (do_rd)
        rd_ptr <= PW'(rd_ptr + 1'b1);
      mem_count <= (PW+1)'(mem_count + {{PW{1'b0}}, do_wr} - {{PW{1'b0}}, do_rd});
    end
  end

  // registered read stage
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else if (do_rd)
    begin
      out_valid <= 1'b1;
      out_data <= mem[rd_ptr];
    end
    else if (out_ready)
      out_valid <= 1'b0;
  end

endmodule

/* File: verif/psl_peer.sv */
// far-side model: rebuilds words from the block's serial output and serializes words into its input
// assumes clk_sys at 100 MHz and two system cycles per serial bit on both directions

`timescale 1ns/1ps

module psl_peer (
  input wire logic clk_sys,
  input wire logic [psl_pkg::LANES-1:0] lane_wire,
  input wire logic clock_wire,
  input wire logic drive_on,
  output logic [psl_pkg::WORD_BITS-1:0] got_word,
  output logic got_shape_ok,
  output logic got_valid,
  input wire logic [psl_pkg::WORD_BITS-1:0] send_word,
  input wire logic send_req,
  output logic send_busy,
  output logic fwd_clock,
  output logic [psl_pkg::LANES-1:0] fwd_lanes
);
  import psl_pkg::*;

  logic prev_clk;

  initial
  begin
    got_word = WORD_RESET;
    got_shape_ok = 1'b0;
    got_valid = 1'b0;
    prev_clk = 1'b0;
    send_busy = 1'b0;
    fwd_clock = 1'b0;
    fwd_lanes = LANES_IDLE;
  end

  // ****************************************
  // receiver side
  // ****************************************
  // a rising forwarded clock opens a frame; each slot is read in its second cycle
  task automatic take_frame();
    logic [WORD_BITS-1:0] w;
    logic ok;
    w = WORD_RESET;
    ok = 1'b1;
    for (int s = 0; s < SLOTS; s++)
    begin
      @(posedge clk_sys);
      for (int l = 0; l < LANES; l++)
        w[l * SLOTS + s] = lane_wire[l];
      if (clock_wire !== ((s < FCLK_HIGH_SLOTS) ? 1'b1 : 1'b0) || drive_on !== 1'b1)
        ok = 1'b0;
      if (s < SLOTS - 1)
        @(posedge clk_sys);
    end
    got_word <= w;
    got_shape_ok <= ok;
    got_valid <= 1'b1;
    prev_clk <= clock_wire; // keeps a back-to-back frame visible
  endtask

  always @(posedge clk_sys)
  begin
    got_valid <= 1'b0;
    prev_clk <= clock_wire;
    if (clock_wire === 1'b1 && prev_clk === 1'b0)
      take_frame();
  end

  // ****************************************
  // sender side
  // ****************************************
  // clock high four slots then low; idle clock stands low, idle lanes flip so stale bits never pass
  task automatic give_frame(input logic [WORD_BITS-1:0] w);
    send_busy <= 1'b1;
    for (int s = 0; s < SLOTS; s++)
    begin
      fwd_clock <= (s < FCLK_HIGH_SLOTS) ? 1'b1 : 1'b0;
      for (int l = 0; l < LANES; l++)
        fwd_lanes[l] <= w[l * SLOTS + s];
      repeat (2) @(posedge clk_sys);
    end
    fwd_clock <= 1'b0;
    fwd_lanes <= ~fwd_lanes;
    repeat (2) @(posedge clk_sys);
    send_busy <= 1'b0;
  endtask

  always @(posedge clk_sys)
    if (send_req === 1'b1 && send_busy === 1'b0)
      give_frame(send_word);

endmodule

/* File: verif/parallel_lvds_serdes_link_tb.sv */
// self-checking bench: peer model on both link directions, notes queued and matched by monitors
// assumes psl_link with a short lock count; strobe clock unrelated in phase to clk_sys

`timescale 1ns/1ps

`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_count++; $display("[ERR] %0t: got %h want %h", $time, got, exp); end end

module parallel_lvds_serdes_link_tb;
  import psl_pkg::*;

  localparam int LOCK = 20;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic strobe = 1'b0;
  logic [WORD_BITS-1:0] word_in = WORD_RESET;
  logic tx_pd_n = 1'b1;
  logic rx_pd_n = 1'b1;
  logic [WORD_BITS-1:0] send_word = WORD_RESET;
  logic send_req = 1'b0;
  logic [LANES-1:0] lanes_out, fwd_lanes;
  logic lanes_oe, fclk_out, fclk_oe, tx_ready, fwd_clock, send_busy, pso, prev_pso;
  logic [WORD_BITS-1:0] word_out, got_word, exp_w, last_w;
  logic got_valid, got_shape_ok, saw_full;
  logic [31:0] r;
  int seed = 32'h5e21_6b06;
  int err_count = 0;
  int checks = 0;
  int n;
  bit strobe_en = 0;
  bit lenient = 1;
  real strobe_half = 80.0;
  logic [WORD_BITS-1:0] txq[$];
  logic [WORD_BITS-1:0] rxq[$];

  always #5 clk_sys = ~clk_sys;

  psl_link #(.LOCK_CYCLES(LOCK), .BIT_CYCLES(2)) psl_link_i (
    .clk_sys(clk_sys), .reset(reset), .parallel_strobe_clock_in(strobe), .parallel_word_in(word_in),
    .tx_low_power_request_n(tx_pd_n), .serial_lane_out(lanes_out), .serial_lane_oe(lanes_oe),
    .forwarded_clock_out(fclk_out), .forwarded_clock_oe(fclk_oe), .tx_word_ready(tx_ready),
    .forwarded_clock_in(fwd_clock), .serial_lane_in(fwd_lanes), .rx_low_power_request_n(rx_pd_n),
    .parallel_word_out(word_out), .parallel_strobe_clock_out(pso));

  psl_peer psl_peer_i (
    .clk_sys(clk_sys), .lane_wire(lanes_oe ? lanes_out : 4'hz), .clock_wire(fclk_oe ? fclk_out : 1'bz),
    .drive_on(lanes_oe & fclk_oe), .got_word(got_word), .got_shape_ok(got_shape_ok), .got_valid(got_valid),
    .send_word(send_word), .send_req(send_req), .send_busy(send_busy), .fwd_clock(fwd_clock),
    .fwd_lanes(fwd_lanes));

  // ****************************************
  // stimulus helpers
  // ****************************************
  // strobe clock stands low while disabled; offset keeps its edges off clk_sys edges
  initial
  begin
    #3.3;
    forever
    begin
      #(strobe_half);
      if (strobe_en || strobe)
        strobe = ~strobe;
    end
  end

  // every rising strobe edge is noted; words ignored in lock or dropped when full are skipped in lenient phases
  always @(posedge strobe)
    txq.push_back(word_in);

  always @(negedge strobe)
  begin
    r = $random(seed);
    word_in <= r[WORD_BITS-1:0];
  end

  task automatic send_rx(input logic [WORD_BITS-1:0] w, input bit note);
    send_word <= w;
    send_req <= 1'b1;
    if (note)
      rxq.push_back(w);
    do @(posedge clk_sys); while (send_busy !== 1'b1);
    send_req <= 1'b0;
    do @(posedge clk_sys); while (send_busy !== 1'b0);
  endtask

  task automatic test_done(input string name);
    $display("test %s done at %0t", name, $time);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ****************************************
  // monitors
  // ****************************************
  always @(posedge clk_sys)
  begin
    prev_pso <= pso;
    if (tx_ready === 1'b0)
      saw_full <= 1'b1;
    if (got_valid === 1'b1)
    begin
      while (lenient && txq.size() > 0 && txq[0] !== got_word)
        void'(txq.pop_front());
      if (txq.size() == 0)
        `CHK(1'b0, 1'b1)
      else
      begin
        exp_w = txq.pop_front();
        `CHK(got_word, exp_w)
        `CHK(got_shape_ok, 1'b1)
      end
    end
    if (pso === 1'b1 && prev_pso === 1'b0)
    begin
      if (rxq.size() == 0)
        `CHK(1'b0, 1'b1)
      else
      begin
        exp_w = rxq.pop_front();
        `CHK(word_out, exp_w)
      end
    end
  end

  // hang guard, sized well above the few tens of microseconds the tests take
  initial
  begin
    #100us;
    err_count++;
    summarize();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    saw_full = 1'b0;
    prev_pso = 1'b0;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    strobe_en = 1;
    @(posedge clk_sys);
    `CHK(word_out, WORD_RESET)
    n = 0;
    while (fclk_out !== 1'b1 && n < 400)
    begin
      @(posedge clk_sys);
      n++;
    end
    `CHK(n >= LOCK && n < 400, 1'b1)
    test_done("lock");
    repeat (160) @(posedge clk_sys);
    lenient = 0;
    repeat (320) @(posedge clk_sys);
    test_done("tx stream");
    // strobes faster than frames: the buffer fills, refuses, then drains once the strobe stops
    lenient = 1;
    saw_full = 1'b0;
    strobe_half = 50.0;
    repeat (800) @(posedge clk_sys);
    // slow rate again until drops have ceased, then every word must arrive once more
    strobe_half = 80.0;
    repeat (640) @(posedge clk_sys);
    lenient = 0;
    strobe_en = 0;
    repeat (400) @(posedge clk_sys);
    `CHK(saw_full, 1'b1)
    `CHK(txq.size() == 0, 1'b1)
    `CHK(fclk_out, 1'b0)
    test_done("buffer");
    tx_pd_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    `CHK({lanes_oe, fclk_oe}, 2'b00)
    tx_pd_n <= 1'b1;
    test_done("tx power down");
    send_rx({WORD_BITS{1'b1}}, 1);
    send_rx(WORD_RESET, 1);
    for (int i = 0; i < 10; i++)
    begin
      r = $random(seed);
      send_rx(r[WORD_BITS-1:0], 1);
    end
    last_w = r[WORD_BITS-1:0];
    repeat (60) @(posedge clk_sys);
    `CHK(word_out, last_w)
    test_done("rx stream");
    rx_pd_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    send_rx(~last_w, 0);
    repeat (30) @(posedge clk_sys);
    `CHK(word_out, last_w)
    `CHK(pso, 1'b0)
    rx_pd_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    send_rx(28'h5a5_a5a5, 1);
    repeat (40) @(posedge clk_sys);
    `CHK(rxq.size() == 0, 1'b1)
    test_done("rx power down");
    summarize();
  end

endmodule
